/* core/pwf_map.vh */
// Register map, field positions and timing figures of the dual-pin waveform block.
// Included by every design file of the block; definitions only.
`ifndef PWF_MAP_VH
`define PWF_MAP_VH

`define PWF_AW             8
`define PWF_DW             32
`define PWF_ADDR_PERIOD    8'h00
`define PWF_ADDR_DUTY0     8'h04
`define PWF_ADDR_DUTY1     8'h08
`define PWF_ADDR_SQHALF    8'h0C
`define PWF_ADDR_PINCFG    8'h10
`define PWF_ADDR_STATUS    8'h14
`define PWF_ADDR_COUNT     8'h18

// Pin function codes, two bits per pin
`define PWF_FN_GPIO        2'h0
`define PWF_FN_PWM         2'h1
`define PWF_FN_SQUARE      2'h2
// Pin configuration nibble per pin: [1:0] function, [2] gpio level, [3] gpio enable
`define PWF_PIN_STRIDE     4
`define PWF_PIN_FN_LSB     0
`define PWF_PIN_LVL        2
`define PWF_PIN_OE         3

`define PWF_RST_PERIOD     32'h0000_03E8
`define PWF_RST_DUTY       32'h0000_0000
`define PWF_RST_SQHALF     32'h0000_0000
`define PWF_RST_PINCFG     8'h00

// Timing figures in their own units
`define PWF_CLK_PS         5000
`define PWF_TICK_PS        1000000
`define PWF_SQ_MIN_PER_PS  250000
`define PWF_RST_HOLD_MS    100
`define PWF_PS_PER_MS      1000000000

`endif

/* core/pwf_chan.v */
// One pulse-width channel: duty shadow register and compare.
// Assumes the shared period counter and boundary pulse come from the top.
`include "pwf_map.vh"
`default_nettype none

module pwf_chan
#(
  parameter W = 32
)
(
  // Clock and reset
  input  wire         mclk_in,
  input  wire         reset_in,
  input  wire         clr_in,
  // Shared timer
  input  wire         bound_in,
  input  wire [W-1:0] cnt_in,
  // Setting
  input  wire [W-1:0] duty_in,
  // Level
  output wire         pwm_out
);

  reg [W-1:0] duty_sh;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      duty_sh <= `PWF_RST_DUTY;
    else if (clr_in)
      duty_sh <= `PWF_RST_DUTY;
    else if (bound_in)
      duty_sh <= duty_in;
  end

  // High from period start until count reaches duty; zero is low, >= period is high
  assign pwm_out = (cnt_in < duty_sh);

endmodule // pwf_chan

`default_nettype wire

/* core/pwf_top.v */
// Dual-pin pulse-width / square-wave generator with a plain register port.
// Assumes a 200 MHz mclk_in; hw_reset_in_n is an asynchronous pin.
//
// Function
// - At most two pins carry a waveform, each either pulse-width or square wave.
// - A pin drives the waveform only when software selects that alternate function.
// - The pulse-width timers are 32-bit counters.
// - The pulse-width timers step on a 1 MHz tick so times are whole microseconds.
// - Software sets the pulse-width frequency, at most 1 MHz.
// - Duty may be anything from 0 % to 100 % inclusive.
// - Both pins share one period but each has its own duty setting.
// - The square wave runs from 0 Hz up to 4 MHz with equal high and low times.
// - The hardware reset pin held low for 100 ms resets the block.
//
// Our own choices: the address-and-strobe port and the address map.
`include "pwf_map.vh"
`default_nettype none

module pwf_top
#(
  parameter integer W            = 32,
  parameter integer NPIN         = 2,
  parameter integer RST_HOLD_CYC = `PWF_RST_HOLD_MS * (`PWF_PS_PER_MS / `PWF_CLK_PS)
)
(
  // Clock and reset
  input  wire                 mclk_in,
  input  wire                 reset_in,
  input  wire                 hw_reset_in_n,
  // Register port
  input  wire [`PWF_AW-1:0]   addr_in,
  input  wire [`PWF_DW-1:0]   wdata_in,
  input  wire                 wr_in,
  input  wire                 rd_in,
  output reg  [`PWF_DW-1:0]   rdata_out,
  // Pins
  output reg  [NPIN-1:0]      general_io_pin_out,
  output reg  [NPIN-1:0]      general_io_pin_oe_out
);

  localparam integer TICK_CYC = `PWF_TICK_PS / `PWF_CLK_PS;
  localparam integer SQ_MIN   = (`PWF_SQ_MIN_PER_PS / 2) / `PWF_CLK_PS;
  localparam integer PCW      = NPIN * `PWF_PIN_STRIDE;

  // Pin reset filter: synchronise then require a long low before acting
  reg        hrst_s1;
  reg        hrst_s2;
  reg [31:0] hold_cnt;
  reg        clr;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      hrst_s1  <= 1'b1;
      hrst_s2  <= 1'b1;
      hold_cnt <= 32'h0000_0000;
      clr      <= 1'b0;
    end
    else
    begin
      hrst_s1 <= hw_reset_in_n;
      hrst_s2 <= hrst_s1;
      if (hrst_s2)
      begin
        hold_cnt <= 32'h0000_0000;
        clr      <= 1'b0;
      end
      else if (hold_cnt >= RST_HOLD_CYC[31:0] - 32'h0000_0001)
        clr <= 1'b1;
      else
        hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end

  // Software registers
  reg [W-1:0]   period;
  reg [W-1:0]   duty0;
  reg [W-1:0]   duty1;
  reg [W-1:0]   sq_half;
  reg [PCW-1:0] pincfg;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      period  <= `PWF_RST_PERIOD;
      duty0   <= `PWF_RST_DUTY;
      duty1   <= `PWF_RST_DUTY;
      sq_half <= `PWF_RST_SQHALF;
      pincfg  <= `PWF_RST_PINCFG;
    end
    else if (clr)
    begin
      period  <= `PWF_RST_PERIOD;
      duty0   <= `PWF_RST_DUTY;
      duty1   <= `PWF_RST_DUTY;
      sq_half <= `PWF_RST_SQHALF;
      pincfg  <= `PWF_RST_PINCFG;
    end
    else if (wr_in)
    begin
      case (addr_in)
        `PWF_ADDR_PERIOD: period  <= wdata_in[W-1:0];
        `PWF_ADDR_DUTY0:  duty0   <= wdata_in[W-1:0];
        `PWF_ADDR_DUTY1:  duty1   <= wdata_in[W-1:0];
        `PWF_ADDR_SQHALF: sq_half <= wdata_in[W-1:0];
        `PWF_ADDR_PINCFG: pincfg  <= wdata_in[PCW-1:0];
        default:          pincfg  <= pincfg;
      endcase
    end
  end

  // 1 MHz tick enable
  reg [15:0] div_cnt;
  wire       tick = (div_cnt == TICK_CYC[15:0] - 16'h0001);
  // No pin shows the pulse width: load at once, nothing can glitch
  reg        pwm_idle;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      div_cnt <= 16'h0000;
    else if (clr || tick || pwm_idle)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // Shared period counter; period zero runs as one tick, the 1 MHz ceiling
  reg  [W-1:0] cnt;
  reg  [W-1:0] per_sh;
  wire [W-1:0] per_eff = (per_sh == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : per_sh;
  wire         bound   = tick && (cnt >= per_eff - {{(W-1){1'b0}}, 1'b1});
  wire         reload  = bound || pwm_idle;

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cnt    <= {W{1'b0}};
      per_sh <= `PWF_RST_PERIOD;
    end
    else if (clr)
    begin
      cnt    <= {W{1'b0}};
      per_sh <= `PWF_RST_PERIOD;
    end
    else if (reload)
    begin
      cnt    <= {W{1'b0}};
      per_sh <= period;
    end
    else if (tick)
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
  end

  wire [NPIN-1:0] pwm_lvl;
  wire [W-1:0]    duty_sel [0:1];
  assign duty_sel[0] = duty0;
  assign duty_sel[1] = duty1;

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : g_chan
      pwf_chan #(.W(W)) u_chan
      (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .clr_in   (clr),
        .bound_in (reload),
        .cnt_in   (cnt),
        .duty_in  (duty_sel[g]),
        .pwm_out  (pwm_lvl[g])
      );
    end
  endgenerate

  // Square wave: half period in clock cycles, zero stops it, floor keeps 4 MHz
  reg  [W-1:0] sq_cnt;
  reg  [W-1:0] sq_sh;
  reg          sq_lvl;
  wire [W-1:0] sq_eff  = (sq_sh < SQ_MIN[W-1:0]) ? SQ_MIN[W-1:0] : sq_sh;
  wire         sq_edge = (sq_cnt >= sq_eff - {{(W-1){1'b0}}, 1'b1});

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sq_cnt <= {W{1'b0}};
      sq_sh  <= `PWF_RST_SQHALF;
      sq_lvl <= 1'b0;
    end
    else if (clr)
    begin
      sq_cnt <= {W{1'b0}};
      sq_sh  <= `PWF_RST_SQHALF;
      sq_lvl <= 1'b0;
    end
    else if (sq_sh == {W{1'b0}})
    begin
      // Stopped: wait low for a non-zero setting
      sq_cnt <= {W{1'b0}};
      sq_lvl <= 1'b0;
      sq_sh  <= sq_half;
    end
    else if (sq_edge)
    begin
      sq_cnt <= {W{1'b0}};
      sq_lvl <= ~sq_lvl;
      // Reload only after the high half, at a period end, so both halves match
      if (sq_lvl)
        sq_sh <= sq_half;
    end
    else
      sq_cnt <= sq_cnt + {{(W-1){1'b0}}, 1'b1};
  end

  // Pin multiplexer, registered
  integer p;
  reg [NPIN-1:0] next_pin;
  reg [NPIN-1:0] next_oe;
  reg [1:0]      fn;

  always @*
  begin
    next_pin = {NPIN{1'b0}};
    next_oe  = {NPIN{1'b0}};
    fn       = `PWF_FN_GPIO;
    pwm_idle = 1'b1;
    for (p = 0; p < NPIN; p = p + 1)
    begin
      fn = pincfg[p*`PWF_PIN_STRIDE + `PWF_PIN_FN_LSB +: 2];
      case (fn)
        `PWF_FN_PWM:
        begin
          next_pin[p] = pwm_lvl[p];
          next_oe[p]  = 1'b1;
          pwm_idle    = 1'b0;
        end
        `PWF_FN_SQUARE:
        begin
          next_pin[p] = sq_lvl;
          next_oe[p]  = 1'b1;
        end
        default:
        begin
          next_pin[p] = pincfg[p*`PWF_PIN_STRIDE + `PWF_PIN_LVL];
          next_oe[p]  = pincfg[p*`PWF_PIN_STRIDE + `PWF_PIN_OE];
        end
      endcase
    end
  end

  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      general_io_pin_out    <= {NPIN{1'b0}};
      general_io_pin_oe_out <= {NPIN{1'b0}};
    end
    else
    begin
      general_io_pin_out    <= next_pin;
      general_io_pin_oe_out <= next_oe;
    end
  end

  // Read port: data the cycle after the strobe, zero for unmapped
  always @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_out <= {`PWF_DW{1'b0}};
    else if (rd_in)
    begin
      case (addr_in)
        `PWF_ADDR_PERIOD: rdata_out <= period;
        `PWF_ADDR_DUTY0:  rdata_out <= duty0;
        `PWF_ADDR_DUTY1:  rdata_out <= duty1;
        `PWF_ADDR_SQHALF: rdata_out <= sq_half;
        `PWF_ADDR_PINCFG: rdata_out <= {{(`PWF_DW-PCW){1'b0}}, pincfg};
        `PWF_ADDR_STATUS: rdata_out <= {{(`PWF_DW-NPIN-2){1'b0}}, clr, sq_lvl, pwm_lvl};
        `PWF_ADDR_COUNT:  rdata_out <= cnt;
        default:          rdata_out <= {`PWF_DW{1'b0}};
      endcase
    end
    else
      rdata_out <= {`PWF_DW{1'b0}};
  end

endmodule // pwf_top

`default_nettype wire

/* sim/pwf_top_asserts.sv */
// Property checker for the dual-pin waveform block.
// Sees only the top module's ports; one clock domain.
`include "pwf_map.vh"
`default_nettype none

module pwf_chk
#(
  parameter integer NPIN         = 2,
  parameter integer RST_HOLD_CYC = 50
)
(
  // Clock and reset
  input wire logic               mclk_in,
  input wire logic               reset_in,
  input wire logic               hw_reset_in_n,
  // Register port
  input wire logic [`PWF_AW-1:0] addr_in,
  input wire logic [`PWF_DW-1:0] wdata_in,
  input wire logic               wr_in,
  input wire logic               rd_in,
  input wire logic [`PWF_DW-1:0] rdata_out,
  // Pins
  input wire logic [NPIN-1:0]    general_io_pin_out,
  input wire logic [NPIN-1:0]    general_io_pin_oe_out
);
  logic [31:0] low_cnt;
  logic        cfg_wr;

  assign cfg_wr = wr_in && addr_in == `PWF_ADDR_PINCFG && hw_reset_in_n;

  // Saturates so a long hold never wraps
  always_ff @(posedge mclk_in or posedge reset_in)
    if (reset_in)
      low_cnt <= 32'h0000_0000;
    else if (hw_reset_in_n)
      low_cnt <= 32'h0000_0000;
    else if (low_cnt != 32'hFFFF_FFFF)
      low_cnt <= low_cnt + 32'h0000_0001;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_rdata_idle: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0000_0000) else $error("stray read data");
  a_unmapped_rd: assert property (
    rd_in && addr_in == 8'h1C |=> rdata_out == 32'h0000_0000) else $error("unmapped read");
  a_duty_wr_rd: assert property (
    wr_in && addr_in == `PWF_ADDR_DUTY1 && hw_reset_in_n ##1 rd_in && addr_in == `PWF_ADDR_DUTY1
    |=> rdata_out == $past(wdata_in, 2)) else $error("duty readback");
  a_fn_drives0: assert property (
    cfg_wr && wdata_in[1] != wdata_in[0] |-> ##[1:3] general_io_pin_oe_out[0])
    else $error("pin 0 not driven");
  a_fn_drives1: assert property (
    cfg_wr && wdata_in[5] != wdata_in[4] |-> ##[1:3] general_io_pin_oe_out[1])
    else $error("pin 1 not driven");
  a_gpio_float: assert property (
    cfg_wr && wdata_in[5:4] == 2'h0 && !wdata_in[7] |-> ##[1:3] !general_io_pin_oe_out[1])
    else $error("pin 1 driven");
  a_rise_hold: assert property (
    $rose(general_io_pin_out[0]) |=> general_io_pin_out[0] [*7]) else $error("short high");
  a_fall_hold: assert property (
    $fell(general_io_pin_out[0]) |=> !general_io_pin_out[0] [*7]) else $error("short low");
  a_pin_reset: assert property (
    low_cnt > RST_HOLD_CYC + 6 |-> general_io_pin_out == '0 && general_io_pin_oe_out == '0)
    else $error("pin reset not clearing");
endmodule // pwf_chk

bind pwf_top pwf_chk #(.NPIN(NPIN), .RST_HOLD_CYC(RST_HOLD_CYC)) u_chk
(
  .mclk_in(mclk_in), .reset_in(reset_in), .hw_reset_in_n(hw_reset_in_n),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .general_io_pin_out(general_io_pin_out),
  .general_io_pin_oe_out(general_io_pin_oe_out)
);

`default_nettype wire

/* sim/test_pwf_top.sv */
// Self-checking bench for pwf_top: registers, pin functions, pin reset.
// Drives every input itself; pin reset hold shortened to 50 cycles.
`include "pwf_map.vh"
`default_nettype none

module test_pwf_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer HOLD = 50;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        hw_reset_in_n = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        rd_d = 1'b0;
  wire  [31:0] rdata_out;
  wire  [1:0]  pin;
  wire  [1:0]  oe;
  integer      fail_count = 0;
  integer      total_checks = 0;
  integer      cycles = 0;
  integer      seed = 32'h1bbc_c426;
  integer      n0;
  integer      n1;
  logic [31:0] rv;
  logic [31:0] exp_q[$];

  pwf_top #(.RST_HOLD_CYC(HOLD)) DUT
  (
    .mclk_in(mclk_in), .reset_in(reset_in), .hw_reset_in_n(hw_reset_in_n),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .general_io_pin_out(pin), .general_io_pin_oe_out(oe)
  );

  initial
  begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reads note the expected word; the monitor compares it a cycle later
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    if (r)
      exp_q.push_back(d);
    @(posedge mclk_in);
  endtask

  task automatic meas(input integer wait_n, input integer n);
    bus(0, 0, 8'h00, 32'h0000_0000);
    repeat (wait_n) @(posedge mclk_in);
    n0 = 0;
    n1 = 0;
    repeat (n)
    begin
      @(posedge mclk_in);
      n0 += (pin[0] === 1'b1);
      n1 += (pin[1] === 1'b1);
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge mclk_in)
  begin
    rd_d <= rd_in;
    if (rd_d)
      chk("rdata", exp_q.pop_front(), rdata_out);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    bus(0, 1, `PWF_ADDR_PERIOD, `PWF_RST_PERIOD);
    bus(0, 1, `PWF_ADDR_DUTY0, `PWF_RST_DUTY);
    bus(0, 1, `PWF_ADDR_SQHALF, `PWF_RST_SQHALF);
    bus(0, 1, `PWF_ADDR_PINCFG, 32'h0000_0000);
    bus(0, 1, 8'h1C, 32'h0000_0000);
    rv = $random(seed);
    bus(1, 0, `PWF_ADDR_DUTY1, rv);
    bus(0, 1, `PWF_ADDR_DUTY1, rv);
    // A short pin-reset pulse must leave settings and pins alone
    bus(1, 0, `PWF_ADDR_PINCFG, 32'h0000_000C);
    hw_reset_in_n <= 1'b0;
    meas(HOLD - 30, 1);
    hw_reset_in_n <= 1'b1;
    meas(8, 1);
    chk("pin keep", 32'h0000_0005, {28'h0, oe, pin});
    bus(0, 1, `PWF_ADDR_DUTY1, rv);
    hw_reset_in_n <= 1'b0;
    meas(HOLD + 10, 1);
    chk("pin clear", 32'h0000_0000, {28'h0, oe, pin});
    bus(1, 0, `PWF_ADDR_DUTY0, 32'h0000_0005);
    bus(0, 1, `PWF_ADDR_STATUS, 32'h0000_0008);
    bus(0, 1, `PWF_ADDR_DUTY0, 32'h0000_0000);
    hw_reset_in_n <= 1'b1;
    meas(8, 1);
    bus(0, 1, `PWF_ADDR_DUTY1, 32'h0000_0000);
    // Period of 4 ticks, pin 0 one tick high, pin 1 full
    bus(1, 0, `PWF_ADDR_PERIOD, 32'h0000_0004);
    bus(1, 0, `PWF_ADDR_DUTY0, 32'h0000_0001);
    bus(1, 0, `PWF_ADDR_DUTY1, 32'h0000_0004);
    bus(1, 0, `PWF_ADDR_PINCFG, 32'h0000_0011);
    meas(1000, 800);
    chk("pin0 high", 32'd200, n0);
    chk("pin1 high", 32'd800, n1);
    chk("oe", 32'h0000_0003, {30'h0, oe});
    bus(1, 0, `PWF_ADDR_DUTY0, 32'h0000_0000);
    meas(1000, 800);
    chk("pin0 zero", 32'd0, n0);
    chk("pin1 same", 32'd800, n1);
    bus(1, 0, `PWF_ADDR_SQHALF, 32'h0000_001E);
    bus(1, 0, `PWF_ADDR_PINCFG, 32'h0000_0021);
    meas(200, 600);
    chk("square", 32'd300, n1);
    bus(1, 0, `PWF_ADDR_SQHALF, 32'h0000_0003);
    meas(200, 500);
    chk("square 4m", 32'd250, n1);
    bus(1, 0, `PWF_ADDR_SQHALF, 32'h0000_0000);
    meas(100, 100);
    chk("square 0", 32'd0, n1);
    bus(1, 0, `PWF_ADDR_PINCFG, 32'h0000_000C);
    meas(4, 1);
    chk("gpio", 32'h0000_0005, {28'h0, oe, pin});
    rv = $random(seed);
    bus(1, 0, `PWF_ADDR_PERIOD, rv);
    bus(0, 1, `PWF_ADDR_PERIOD, rv);
    meas(3, 1);
    wrap_up();
  end
endmodule // test_pwf_top

`default_nettype wire
